/* rtl/sacs_sequencer.sv */
// Successive approximation conversion sequencer, the device's digital core.
// Assumes compare_high comes from a comparator latch clocked by clock;
// conversion_start_n is an asynchronous pin from the host.
//
// Behaviour
// RULE_01: A falling edge on the start strobe begins a conversion; a held low does not.
// RULE_02: Busy is low throughout a conversion and returns high when it completes.
// RULE_03: Start edges during a conversion are ignored; conversions never abort or restart.
// RULE_04: The approximation register is cleared before the first bit decision.
// RULE_05: Fourteen bits resolve one per step, MSB first, kept or dropped by comparator.
// RULE_06: After the last decision the whole word is loaded into the output latches.
// RULE_07: Steps are timed from the internal clock; the host supplies no clock.
// RULE_08: Busy falls shortly after the strobe edge; data is valid as busy rises.
// RULE_09: Acquisition plus conversion fits in 454 ns; host keeps that spacing.
// RULE_10: Host allows at least 70 ns acquisition after a conversion before restarting.
// RULE_11: Host releases the strobe within 225 ns of its fall, or after busy rises.
// RULE_12: Output code is two's complement, toggling all zeros and all ones near zero.
// RULE_13: Output latches hold the previous result until the next load.
// RULE_14: Host captures the result on or after busy rising, its end-of-conversion.
`include "sacs_consts.svh"
`default_nettype none

module sacs_sequencer #(
    parameter int FIFO_DEPTH = `SACS_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic conversion_start_n,
    input wire logic compare_high,
    output logic busy_n,
    output sacs_pkg::sacs_word_t result_bits,
    output sacs_pkg::sacs_word_t dac_code,
    output logic hold_en,
    output logic zero_en,
    output logic stream_valid,
    output sacs_pkg::sacs_word_t stream_data,
    input wire logic stream_ready,
    output logic start_ignored,
    output logic acq_short,
    output logic release_late
);

    import sacs_pkg::*;

    localparam logic [3:0] STEP_LAST = 4'(`SACS_STEP_CYC - 1);
    localparam logic [3:0] BIT_TOP = 4'(`SACS_MSB_POS);
    localparam logic [4:0] ACQ_DONE = 5'(`SACS_ACQ_CYC);
    localparam logic [6:0] RELEASE_LIM = 7'(`SACS_RELEASE_CYC);
    localparam logic [6:0] SINCE_MAX = 7'h7f;

    // Strobe synchroniser and filtered level
    logic start_s1_r;
    logic start_s2_r;
    logic start_s3_r;
    logic start_level_r;
    logic start_change;
    logic start_fall;
    logic start_rise;

    // Sequencer state
    sacs_state_e state_r;
    logic [3:0] step_cnt_r;
    logic [3:0] bit_idx_r;
    sacs_word_t sar_r;
    logic step_first;
    logic step_last;
    logic last_bit;
    logic converting;

    // Output registers
    logic busy_n_r;
    sacs_word_t result_r;
    logic hold_en_r;
    logic zero_en_r;
    logic start_ignored_r;
    logic acq_short_r;
    logic release_late_r;

    // Host timing monitors
    logic [4:0] acq_cnt_r;
    logic [6:0] since_cnt_r;

    // Buffer handshake
    logic fifo_in_ready;
    logic store_fire;
    sacs_word_t code_tc;

    // Three-stage strobe synchroniser
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            start_s1_r <= 1'b1;
            start_s2_r <= 1'b1;
            start_s3_r <= 1'b1;
        end
        else
        begin
            start_s1_r <= conversion_start_n;
            start_s2_r <= start_s1_r;
            start_s3_r <= start_s2_r;
        end
    end

    // A change counts once stages two and three agree
    assign start_change = (start_s2_r == start_s3_r) && (start_s3_r != start_level_r);
    assign start_fall = start_change && !start_s3_r; // see RULE_01
    assign start_rise = start_change && start_s3_r;

    // Filtered strobe level, idle high
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            start_level_r <= 1'b1;
        end
        else if (start_change)
        begin
            start_level_r <= start_s3_r;
        end
    end

    // Step decode
    assign converting = (state_r != ST_IDLE);
    assign step_first = (step_cnt_r == 4'h0);
    assign step_last = (step_cnt_r == STEP_LAST);
    assign last_bit = (bit_idx_r == 4'h0);
    assign store_fire = (state_r == ST_STORE) && fifo_in_ready;

    // Offset-binary approximation to two's complement
    assign code_tc = {~sar_r[`SACS_MSB_POS], sar_r[`SACS_MSB_POS-1:0]}; // see RULE_12

    // Phase sequencing
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            state_r <= ST_IDLE;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (start_fall)
                    begin
                        state_r <= ST_CLEAR; // see RULE_01
                    end
                end
                ST_CLEAR:
                begin
                    state_r <= ST_TRIAL;
                end
                ST_TRIAL:
                begin
                    if (step_last && last_bit)
                    begin
                        state_r <= ST_STORE;
                    end
                end
                ST_STORE:
                begin
                    if (fifo_in_ready)
                    begin
                        state_r <= ST_IDLE; // see RULE_03
                    end
                end
                default:
                begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Internal step timer, one bit per step
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            step_cnt_r <= 4'h0;
        end
        else if ((state_r != ST_TRIAL) || step_last)
        begin
            step_cnt_r <= 4'h0;
        end
        else
        begin
            step_cnt_r <= step_cnt_r + 4'h1; // see RULE_07
        end
    end

    // Bit pointer walks from MSB down
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            bit_idx_r <= BIT_TOP;
        end
        else if (state_r == ST_CLEAR)
        begin
            bit_idx_r <= BIT_TOP; // see RULE_05
        end
        else if ((state_r == ST_TRIAL) && step_last && !last_bit)
        begin
            bit_idx_r <= bit_idx_r - 4'h1; // see RULE_05
        end
    end

    // Approximation register: clear, trial, decide
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            sar_r <= `SACS_RST_CODE;
        end
        else if (state_r == ST_CLEAR)
        begin
            sar_r <= `SACS_RST_CODE; // see RULE_04
        end
        else if (state_r == ST_TRIAL)
        begin
            if (step_first)
            begin
                sar_r[bit_idx_r] <= 1'b1; // see RULE_05
            end
            else if (step_last && !compare_high)
            begin
                sar_r[bit_idx_r] <= 1'b0; // see RULE_05
            end
        end
    end

    // Busy status low across the conversion
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            busy_n_r <= 1'b1;
        end
        else if ((state_r == ST_IDLE) && start_fall)
        begin
            busy_n_r <= 1'b0; // see RULE_02, RULE_08
        end
        else if (store_fire)
        begin
            busy_n_r <= 1'b1; // see RULE_02, RULE_08
        end
    end

    // Output latches load with busy rising, else hold
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            result_r <= `SACS_RST_CODE;
        end
        else if (store_fire)
        begin
            result_r <= code_tc; // see RULE_06, RULE_08, RULE_13
        end
    end

    // Track/hold and comparator zeroing controls
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            hold_en_r <= 1'b0;
            zero_en_r <= 1'b1;
        end
        else if ((state_r == ST_IDLE) && start_fall)
        begin
            hold_en_r <= 1'b1;
            zero_en_r <= 1'b0;
        end
        else if (store_fire)
        begin
            hold_en_r <= 1'b0;
            zero_en_r <= 1'b1;
        end
    end

    // Acquisition time since last conversion
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            acq_cnt_r <= ACQ_DONE;
        end
        else if (converting)
        begin
            acq_cnt_r <= 5'h00;
        end
        else if (acq_cnt_r != ACQ_DONE)
        begin
            acq_cnt_r <= acq_cnt_r + 5'h01; // see RULE_10
        end
    end

    // Time since the accepted start edge
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            since_cnt_r <= 7'h00;
        end
        else if ((state_r == ST_IDLE) && start_fall)
        begin
            since_cnt_r <= 7'h00;
        end
        else if (converting && (since_cnt_r != SINCE_MAX))
        begin
            since_cnt_r <= since_cnt_r + 7'h01;
        end
    end

    // One-cycle diagnostics of host timing
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            start_ignored_r <= 1'b0;
            acq_short_r <= 1'b0;
            release_late_r <= 1'b0;
        end
        else
        begin
            start_ignored_r <= start_fall && converting; // see RULE_03
            acq_short_r <= start_fall && !converting && (acq_cnt_r != ACQ_DONE); // see RULE_09, RULE_10
            release_late_r <= start_rise && converting && (since_cnt_r > RELEASE_LIM); // see RULE_11
        end
    end

    // Result buffer; a full buffer stalls the store phase
    sacs_fifo #(
        .WIDTH(`SACS_RES_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .reset_n(reset_n),
        .in_valid(state_r == ST_STORE),
        .in_ready(fifo_in_ready),
        .in_data(code_tc),
        .out_valid(stream_valid),
        .out_data(stream_data),
        .out_ready(stream_ready)
    );

    // Port drive, all from flip-flops
    assign busy_n = busy_n_r;
    assign result_bits = result_r;
    assign dac_code = sar_r;
    assign hold_en = hold_en_r;
    assign zero_en = zero_en_r;
    assign start_ignored = start_ignored_r;
    assign acq_short = acq_short_r;
    assign release_late = release_late_r;

endmodule : sacs_sequencer

`default_nettype wire

/* rtl/sacs_consts.svh */
// Constants for the conversion sequencer: clock rate, step timing,
// acquisition and strobe-release windows, result layout, buffer depth.
// Assumes the including file compiles after it and uses only the macros.
`ifndef SACS_CONSTS_SVH
`define SACS_CONSTS_SVH

// Core clock rate in MHz (4 ns period)
`define SACS_CLK_MHZ 250

// Result width and layout
`define SACS_RES_BITS 14
`define SACS_MSB_POS 13

// Conversion time in ns and per-bit step length in cycles
`define SACS_T_CONV_NS 330
`define SACS_STEP_CYC (((`SACS_T_CONV_NS * `SACS_CLK_MHZ) / 1000) / `SACS_RES_BITS)

// Least acquisition time in ns, rounded up to cycles
`define SACS_T_ACQ_NS 70
`define SACS_ACQ_CYC (((`SACS_T_ACQ_NS * `SACS_CLK_MHZ) + 999) / 1000)

// Longest safe strobe-release delay in ns, rounded down to cycles
`define SACS_T_RELEASE_NS 225
`define SACS_RELEASE_CYC ((`SACS_T_RELEASE_NS * `SACS_CLK_MHZ) / 1000)

// Result buffer depth in words
`define SACS_FIFO_DEPTH 16

// Reset values
`define SACS_RST_CODE 14'h0000

`endif

/* rtl/sacs_pkg.sv */
// Types shared by the conversion sequencer and its result buffer.
// Assumes sacs_consts.svh is on the include path.
`include "sacs_consts.svh"
`default_nettype none

package sacs_pkg;

    // One conversion result or trial word
    typedef logic [`SACS_MSB_POS:0] sacs_word_t;

    // Sequencer phases
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CLEAR,
        ST_TRIAL,
        ST_STORE
    } sacs_state_e;

endpackage : sacs_pkg

`default_nettype wire

/* rtl/sacs_fifo.sv */
// Result buffer: memory FIFO with a registered output word.
// Assumes a single clock and synchronous active-low reset.
`default_nettype none

module sacs_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;
    logic out_valid_r;
    logic [WIDTH-1:0] out_data_r;
    logic push;
    logic pop;

    // Handshake terms
    assign in_ready = (count_r != (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign push = in_valid && in_ready;
    assign pop = (count_r != '0) && (!out_valid_r || out_ready);
    assign out_valid = out_valid_r;
    assign out_data = out_data_r;

    // Storage write
    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop)
            begin
                count_r <= count_r + 1'b1;
            end
            else if (pop && !push)
            begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    // Output register stage
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            out_valid_r <= 1'b0;
            out_data_r <= '0;
        end
        else if (pop)
        begin
            out_valid_r <= 1'b1;
            out_data_r <= mem_r[rd_ptr_r];
        end
        else if (out_ready)
        begin
            out_valid_r <= 1'b0;
        end
    end

endmodule : sacs_fifo

`default_nettype wire

/* verification/sacs_host_model.sv */
// Host and comparator model facing the conversion sequencer.
// Assumes the bench calls convert at a rising edge of clock.
`default_nettype none

module sacs_host_model (
    input wire logic clock,
    input wire logic busy_n,
    input wire sacs_pkg::sacs_word_t dac_code,
    input wire sacs_pkg::sacs_word_t result_bits,
    output logic conversion_start_n,
    output var logic compare_high
);
    timeunit 1ns;
    timeprecision 1ps;
    import sacs_pkg::*;

    sacs_word_t target_r;
    logic [9:0] low_cnt_r;

    // Strobe idles high
    initial
    begin
        conversion_start_n = 1'b1;
        target_r = 14'h0000;
    end

    // Comparator latch: keep the trial while it does not pass the held input
    always_ff @(posedge clock)
        compare_high <= (dac_code <= target_r);

    // Cycles busy has stood low
    always_ff @(posedge clock)
        low_cnt_r <= busy_n ? 10'h000 : low_cnt_r + 10'h001;

    // One conversion: strobe, optional second fall, wait, capture, acquire
    task automatic convert(input sacs_word_t tgt, input int low_cyc, input bit refall, input int lim, input int gap,
                           output sacs_word_t got, output int n, output bit ok);
        int i;
        target_r <= tgt;
        conversion_start_n <= 1'b0;
        repeat (low_cyc) @(posedge clock);
        conversion_start_n <= 1'b1;
        if (refall)
        begin
            repeat (10) @(posedge clock);
            conversion_start_n <= 1'b0;
            repeat (10) @(posedge clock);
            conversion_start_n <= 1'b1;
        end
        i = 0;
        @(negedge clock);
        while (busy_n !== 1'b1 && i < lim)
        begin
            @(negedge clock);
            i++;
        end
        ok = (i < lim);
        got = result_bits;
        n = low_cnt_r;
        @(posedge clock);
        if (ok)
            repeat (gap) @(posedge clock);
    endtask : convert

endmodule : sacs_host_model

`default_nettype wire

/* verification/sacs_chk.sv */
// Checker for the conversion sequencer: busy timing, trials, latches, stream.
// Assumes it is bound onto sacs_sequencer and sees only its ports.
`default_nettype none

module sacs_chk (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic conversion_start_n,
    input wire logic compare_high,
    input wire logic busy_n,
    input wire sacs_pkg::sacs_word_t result_bits,
    input wire sacs_pkg::sacs_word_t dac_code,
    input wire logic hold_en,
    input wire logic zero_en,
    input wire logic stream_valid,
    input wire sacs_pkg::sacs_word_t stream_data,
    input wire logic stream_ready,
    input wire logic start_ignored,
    input wire logic acq_short,
    input wire logic release_late
);
    timeunit 1ns;
    timeprecision 1ps;
    import sacs_pkg::*;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    logic [9:0] busy_cnt_r;

    // Cycles busy has stood low, saturating
    always_ff @(posedge clock)
    begin
        if (!reset_n || busy_n)
            busy_cnt_r <= 10'h000;
        else if (busy_cnt_r != 10'h3ff)
            busy_cnt_r <= busy_cnt_r + 10'h001;
    end

    // Cleared register, then the top trial bit alone
    sequence s_sar_clear;
        dac_code == 14'h0000;
    endsequence
    sequence s_msb_trial;
        dac_code == 14'h2000;
    endsequence

    AST_BUSY_FALL: assert property (busy_n && $fell(conversion_start_n) |-> ##[3:4] !busy_n)
        else $error("busy did not fall after start edge");
    AST_BUSY_LOW: assert property ($fell(busy_n) |-> !busy_n throughout (##71 1'b1))
        else $error("busy rose before conversion end");
    AST_BUSY_END: assert property (busy_cnt_r == 10'h048 && stream_ready && $past(stream_ready) |-> busy_n)
        else $error("busy stayed low past conversion end");
    AST_IGNORE: assert property (!busy_n && $fell(conversion_start_n) |-> ##[3:4] start_ignored)
        else $error("start edge during conversion not flagged");
    AST_CLEAR_FIRST: assert property ($fell(busy_n) |-> ##[0:2] s_sar_clear ##1 s_msb_trial)
        else $error("register not cleared before first trial");
    AST_MSB_FIRST: assert property ($rose(dac_code[13]) |-> (!dac_code[12])[*5] ##1 dac_code[12])
        else $error("second trial not five cycles after first");
    AST_RES_HOLD: assert property (!$rose(busy_n) |-> $stable(result_bits))
        else $error("result changed outside a load");
    AST_LOAD: assert property ($rose(busy_n) && !stream_valid |-> ##[1:2] (stream_valid && stream_data == result_bits))
        else $error("loaded word not offered on stream");
    AST_HOLD_EN: assert property (hold_en != busy_n && zero_en == busy_n)
        else $error("hold and zero enables disagree with busy");
    AST_STREAM_HOLD: assert property (stream_valid && !stream_ready |=> stream_valid && $stable(stream_data))
        else $error("stream word dropped before acceptance");

endmodule : sacs_chk

bind sacs_sequencer sacs_chk u_chk (
    .clock(clock), .reset_n(reset_n), .conversion_start_n(conversion_start_n), .compare_high(compare_high),
    .busy_n(busy_n), .result_bits(result_bits), .dac_code(dac_code), .hold_en(hold_en), .zero_en(zero_en),
    .stream_valid(stream_valid), .stream_data(stream_data), .stream_ready(stream_ready),
    .start_ignored(start_ignored), .acq_short(acq_short), .release_late(release_late)
);

`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the conversion sequencer and its result buffer.
// Assumes the design, sacs_host_model and sacs_chk are compiled first.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sacs_pkg::*;

    logic clock, reset_n, stream_ready, conversion_start_n, compare_high, busy_n;
    logic hold_en, zero_en, stream_valid, start_ignored, acq_short, release_late;
    sacs_word_t result_bits, dac_code, stream_data, got;
    int n_fail, checks, n, n_ign, n_acq, n_late;
    bit ok;

    `define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; $display("ERROR %0t: got %h exp %h", $time, a, b); end end

    sacs_sequencer DUT (
        .clock(clock), .reset_n(reset_n), .conversion_start_n(conversion_start_n), .compare_high(compare_high),
        .busy_n(busy_n), .result_bits(result_bits), .dac_code(dac_code), .hold_en(hold_en), .zero_en(zero_en),
        .stream_valid(stream_valid), .stream_data(stream_data), .stream_ready(stream_ready),
        .start_ignored(start_ignored), .acq_short(acq_short), .release_late(release_late)
    );

    sacs_host_model host (
        .clock(clock), .busy_n(busy_n), .dac_code(dac_code), .result_bits(result_bits),
        .conversion_start_n(conversion_start_n), .compare_high(compare_high)
    );

    // 250 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Counts of one-cycle diagnostic pulses, sampled where settled
    always @(negedge clock)
    begin
        if (start_ignored === 1'b1)
            n_ign++;
        if (acq_short === 1'b1)
            n_acq++;
        if (release_late === 1'b1)
            n_late++;
    end

    // Verdict and end of run
    task automatic conclude;
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    // One conversion through the host, result and busy length judged
    task automatic run(input sacs_word_t tgt, input int low_cyc, input bit refall, input bit chk_len);
        host.convert(tgt, low_cyc, refall, 400, 20, got, n, ok);
        `CHK(ok, 1'b1)
        if (!ok)
            conclude();
        `CHK(got, tgt ^ 14'h2000)
        if (chk_len)
            `CHK(n, 72)
    endtask : run

    // Values straight after reset
    task automatic t_reset;
        `CHK(busy_n, 1'b1)
        `CHK(result_bits, 14'h0000)
        `CHK(hold_en, 1'b0)
        `CHK(zero_en, 1'b1)
        `CHK(stream_valid, 1'b0)
    endtask : t_reset

    // Boundary, near-zero and alternating-bit codes
    task automatic t_codes;
        sacs_word_t tv[6];
        tv = '{14'h0000, 14'h3fff, 14'h2000, 14'h1fff, 14'h2aaa, 14'h1555};
        foreach (tv[i])
            run(tv[i], 10, 1'b0, 1'b1);
    endtask : t_codes

    // Second fall mid-conversion changes nothing
    task automatic t_refall;
        int ign0;
        ign0 = n_ign;
        run(14'h0abc, 10, 1'b1, 1'b1);
        `CHK(n_ign - ign0, 1)
    endtask : t_refall

    // Late strobe release, then a start with short acquisition: one pulse each
    task automatic t_diag;
        `CHK(n_acq + n_late, 0)
        host.convert(14'h1234, 60, 1'b0, 400, 0, got, n, ok);
        `CHK(ok, 1'b1)
        `CHK(got, 14'h3234)
        `CHK(n, 72)
        host.convert(14'h2345, 10, 1'b0, 400, 20, got, n, ok);
        `CHK(got, 14'h0345)
        `CHK(n_late, 1)
        `CHK(n_acq, 1)
    endtask : t_diag

    // Strobe held low past busy rising starts nothing new
    task automatic t_held;
        fork
            run(14'h3456, 100, 1'b0, 1'b0);
            begin
                repeat (95) @(negedge clock);
                `CHK(busy_n, 1'b1)
            end
        join
    endtask : t_held

    // Fill the buffer until the store stalls, then drain in order
    task automatic t_fill;
        sacs_word_t exp_q[$];
        sacs_word_t tgt;
        int k;
        stream_ready <= 1'b0;
        for (int i = 0; i < 17; i++)
        begin
            tgt = 14'h0011 + 14'h0123 * 14'(i);
            run(tgt, 10, 1'b0, 1'b1);
            exp_q.push_back(tgt ^ 14'h2000);
        end
        tgt = 14'h3210;
        host.convert(tgt, 10, 1'b0, 150, 20, got, n, ok);
        `CHK(ok, 1'b0)
        `CHK(busy_n, 1'b0)
        `CHK(result_bits, exp_q[16])
        exp_q.push_back(tgt ^ 14'h2000);
        stream_ready <= 1'b1;
        k = 0;
        for (int c = 0; c < 300 && k < 18; c++)
        begin
            @(negedge clock);
            if (stream_valid === 1'b1)
            begin
                `CHK(stream_data, exp_q[k])
                k++;
            end
        end
        `CHK(k, 18)
        if (k != 18)
            conclude();
        `CHK(result_bits, exp_q[17])
        @(negedge clock);
        `CHK(stream_valid, 1'b0)
    endtask : t_fill

    // Main sequence
    initial
    begin
        n_fail = 0;
        checks = 0;
        n_ign = 0;
        n_acq = 0;
        n_late = 0;
        reset_n = 1'b0;
        stream_ready = 1'b1;
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        @(negedge clock);
        t_reset();
        @(posedge clock);
        t_codes();
        t_refall();
        t_held();
        t_diag();
        t_fill();
        conclude();
    end

endmodule : testbench

`default_nettype wire
